// ==== core/pmx_core.sv ====
`timescale 1ns/10ps
module pmx_core #(
    parameter int unsigned TICK_CYCLES = pmx_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pmx_pkg::AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [pmx_pkg::DW-1:0] wb_dat_i,
    output logic [pmx_pkg::DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dec_valid_i,
    input wire logic dec_priv_i,
    input wire logic dec_undef_i,
    input wire logic dec_feat_miss_i,
    input wire logic dec_is_exec_i,
    input wire logic dec_exec_tgt_i,
    output logic dec_allow_o,
    output logic fetch_en_o,
    input wire logic fetch_done_i,
    input wire logic stor_valid_i,
    input wire logic [pmx_pkg::KEY_W-1:0] stor_key_i,
    output logic stor_ok_o,
    input wire logic [pmx_pkg::GPR_W-1:0] gpr_num_i,
    output logic [pmx_pkg::GPR_W:0] gpr_adr_o,
    output logic ascii_o,
    input wire logic br_taken_i,
    input wire logic [pmx_pkg::TA_W-1:0] br_next_ia_i,
    input wire logic [pmx_pkg::ILC_W-1:0] br_ilc_i,
    output logic trace_wr_o,
    output logic [pmx_pkg::TA_W-1:0] trace_adr_o,
    output logic [pmx_pkg::DW-1:0] trace_dat_o,
    input wire logic wcs_req_i,
    output logic wcs_grant_o,
    input wire logic cpu_fault_i,
    input wire logic io_fault_i,
    input wire logic io_subsys_i,
    output logic int_req_o,
    input wire logic int_ack_i
);
    logic ack;
    logic acc;
    logic wr;
    logic [pmx_pkg::DW-1:0] wm;
    logic [pmx_pkg::DW-1:0] rd;
    logic [pmx_pkg::MODE_W-1:0] mode;
    logic [pmx_pkg::KEY_W-1:0] key;
    logic pmask;
    logic [pmx_pkg::CAUSE_W-1:0] cause;
    logic [pmx_pkg::CAUSE_W-1:0] set;
    logic [pmx_pkg::CAUSE_W-1:0] clr;
    logic [pmx_pkg::TA_W-1:0] tbase;
    logic [pmx_pkg::TP_W-1:0] tptr;
    logic down;
    logic prog_exc;
    logic exc_op;
    logic exc_priv;
    logic exc_exec;
    logic exc_prot;
    logic mchk;
    logic tick;
    logic expire;
    logic [pmx_pkg::RUN_W-1:0] run_cnt;
    logic [pmx_pkg::INTV_W-1:0] intv_cnt;

    function automatic logic [pmx_pkg::DW-1:0] merge(
        input logic [pmx_pkg::DW-1:0] old,
        input logic [pmx_pkg::DW-1:0] nw,
        input logic [pmx_pkg::DW-1:0] m
    );
        merge = (old & ~m) | (nw & m);
    endfunction

    // bus slave: ack one cycle after the strobe, dropped the next cycle
    assign acc = wb_cyc_i & wb_stb_i;
    assign wr = acc & wb_we_i & ack;
    assign wb_ack_o = ack;

    genvar g;
    for (g = 0; g < 4; g++) begin : g_lane
        assign wm[8*g +: 8] = {8{wb_sel_i[g]}};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= acc & ~ack;
        end
    end

    always_comb begin
        rd = '0;
        case (wb_adr_i)
            pmx_pkg::ADR_MODE: rd[pmx_pkg::MODE_W-1:0] = mode;
            pmx_pkg::ADR_CTRL: begin
                rd[pmx_pkg::KEY_W-1:0] = key;
                rd[pmx_pkg::CTRL_PMASK] = pmask;
            end
            pmx_pkg::ADR_CAUSE: rd[pmx_pkg::CAUSE_W-1:0] = cause;
            pmx_pkg::ADR_TBASE: rd[pmx_pkg::TA_W-1:0] = tbase;
            pmx_pkg::ADR_TPTR: rd[pmx_pkg::TP_W-1:0] = tptr;
            pmx_pkg::ADR_RUN: rd = run_cnt;
            pmx_pkg::ADR_TCTL: rd[pmx_pkg::TCTL_DOWN] = down;
            pmx_pkg::ADR_INTV: rd[pmx_pkg::INTV_W-1:0] = intv_cnt;
            default: rd = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (acc && !ack) begin
            wb_dat_o <= rd;
        end
    end

    // taking an interrupt overrides a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= pmx_pkg::MODE_RST;
        end else if (int_ack_i) begin
            mode[pmx_pkg::MB_PROB] <= 1'b0; // RULE_18
            mode[pmx_pkg::MB_UREGS] <= 1'b0;
            mode[pmx_pkg::MB_WAIT] <= 1'b0;
        end else if (wr && wb_adr_i == pmx_pkg::ADR_MODE) begin
            mode <= (mode & ~wm[pmx_pkg::MODE_W-1:0]) |
                    (wb_dat_i[pmx_pkg::MODE_W-1:0] &
                     wm[pmx_pkg::MODE_W-1:0]); // RULE_01
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key <= pmx_pkg::KEY_RST;
            pmask <= 1'b1;
        end else if (wr && wb_adr_i == pmx_pkg::ADR_CTRL) begin
            key <= (key & ~wm[pmx_pkg::KEY_W-1:0]) |
                   (wb_dat_i[pmx_pkg::KEY_W-1:0] & wm[pmx_pkg::KEY_W-1:0]);
            pmask <= wb_sel_i[1] ? wb_dat_i[pmx_pkg::CTRL_PMASK] : pmask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tbase <= '0;
            down <= 1'b0;
        end else if (wr && wb_adr_i == pmx_pkg::ADR_TBASE) begin
            tbase <= (tbase & ~wm[pmx_pkg::TA_W-1:0]) |
                     (wb_dat_i[pmx_pkg::TA_W-1:0] & wm[pmx_pkg::TA_W-1:0]);
        end else if (wr && wb_adr_i == pmx_pkg::ADR_TCTL && wb_sel_i[0]) begin
            down <= wb_dat_i[pmx_pkg::TCTL_DOWN];
        end
    end

    // decode checks; supervisor state never bypasses the key compare
    assign exc_priv = dec_valid_i & dec_priv_i &
                      mode[pmx_pkg::MB_PROB]; // RULE_03
    assign exc_op = dec_valid_i & (dec_undef_i | dec_feat_miss_i); // RULE_16
    assign exc_exec = dec_valid_i & dec_is_exec_i & dec_exec_tgt_i; // RULE_17
    assign exc_prot = stor_valid_i & (stor_key_i != key); // RULE_05
    assign stor_ok_o = stor_valid_i & (stor_key_i == key); // RULE_04
    assign dec_allow_o = dec_valid_i & ~exc_priv & ~exc_op & ~exc_exec &
                         ~mode[pmx_pkg::MB_WAIT]; // RULE_02
    assign prog_exc = exc_op | exc_priv | exc_exec | exc_prot;
    assign mchk = cpu_fault_i | (io_fault_i & ~io_subsys_i) |
                  (prog_exc & ~pmask); // RULE_15

    always_comb begin
        set = '0;
        set[pmx_pkg::CB_OP] = exc_op & pmask;
        set[pmx_pkg::CB_PRIV] = exc_priv & pmask;
        set[pmx_pkg::CB_EXEC] = exc_exec & pmask;
        set[pmx_pkg::CB_PROT] = exc_prot & pmask;
        set[pmx_pkg::CB_ANA] = fetch_done_i & mode[pmx_pkg::MB_MON]; // RULE_10
        set[pmx_pkg::CB_MCHK] = mchk;
        set[pmx_pkg::CB_TMR] = expire; // RULE_19
    end

    always_comb begin
        clr = '0;
        if (wr && wb_adr_i == pmx_pkg::ADR_CAUSE && wb_sel_i[0]) begin
            clr = wb_dat_i[pmx_pkg::CAUSE_W-1:0];
        end
    end

    // write one to clear; a new event in the same cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause <= '0;
        end else begin
            cause <= (cause & ~clr) | set; // RULE_20
        end
    end

    // requests are accepted even while waiting
    assign int_req_o = |cause; // RULE_08
    assign fetch_en_o = ~mode[pmx_pkg::MB_WAIT]; // RULE_08

    assign gpr_adr_o = {mode[pmx_pkg::MB_UREGS], gpr_num_i}; // RULE_06
    assign ascii_o = mode[pmx_pkg::MB_ASCII]; // RULE_07
    assign wcs_grant_o = wcs_req_i & mode[pmx_pkg::MB_EMUL]; // RULE_11

    // trace table pointer wraps at its width so the table stays bounded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trace_wr_o <= 1'b0;
            trace_adr_o <= '0;
            trace_dat_o <= '0;
            tptr <= '0;
        end else begin
            trace_wr_o <= br_taken_i & mode[pmx_pkg::MB_TRACE]; // RULE_09
            if (wr && wb_adr_i == pmx_pkg::ADR_TBASE) begin
                tptr <= '0;
            end else if (br_taken_i && mode[pmx_pkg::MB_TRACE]) begin
                trace_adr_o <= tbase +
                    pmx_pkg::TA_W'(tptr) * pmx_pkg::TA_W'(pmx_pkg::TRC_STEP);
                trace_dat_o <= '0;
                trace_dat_o[pmx_pkg::TA_W-1:0] <= br_next_ia_i;
                trace_dat_o[pmx_pkg::TRC_ILC_LSB +: pmx_pkg::ILC_W]
                    <= br_ilc_i; // RULE_09
                tptr <= tptr + pmx_pkg::TP_W'(1);
            end
        end
    end

    pmx_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_wr_i(wr && wb_adr_i == pmx_pkg::ADR_RUN),
        .run_val_i(merge(run_cnt, wb_dat_i, wm)),
        .down_i(down),
        .intv_wr_i(wr && wb_adr_i == pmx_pkg::ADR_INTV),
        .intv_val_i(wb_dat_i[pmx_pkg::INTV_W-1:0]),
        .tick_o(tick),
        .run_o(run_cnt),
        .intv_o(intv_cnt),
        .expire_o(expire)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        acc && !ack;
    endsequence
    sequence s_ack_once;
        ack ##1 !ack;
    endsequence
    property p_wb_ack;
        s_req |=> s_ack_once;
    endproperty
    a_wb_ack: assert property (p_wb_ack)
        else $error("bus ack not a single cycle after request");

    property p_priv_refuse;
        dec_valid_i && dec_priv_i && mode[pmx_pkg::MB_PROB] |-> !dec_allow_o;
    endproperty
    a_priv_refuse: assert property (p_priv_refuse) // RULE_02
        else $error("privileged instruction allowed in problem mode");

    property p_priv_exc;
        exc_priv && pmask |=> cause[pmx_pkg::CB_PRIV];
    endproperty
    a_priv_exc: assert property (p_priv_exc) // RULE_03
        else $error("privileged exception not flagged");

    property p_prot;
        stor_valid_i && stor_key_i != key && !mode[pmx_pkg::MB_PROB]
            |=> cause[pmx_pkg::CB_PROT] || cause[pmx_pkg::CB_MCHK];
    endproperty
    a_prot: assert property (p_prot) // RULE_04
        else $error("key mismatch in supervisor mode not flagged");

    property p_wait_irq;
        mode[pmx_pkg::MB_WAIT] && |cause |-> !fetch_en_o && int_req_o;
    endproperty
    a_wait_irq: assert property (p_wait_irq) // RULE_08
        else $error("wait mode fetching or blocking interrupts");

    sequence s_trace_hit;
        br_taken_i && mode[pmx_pkg::MB_TRACE];
    endsequence
    property p_trace;
        s_trace_hit |=> trace_wr_o &&
            trace_dat_o[pmx_pkg::TA_W-1:0] == $past(br_next_ia_i);
    endproperty
    a_trace: assert property (p_trace) // RULE_09
        else $error("trace entry missing after taken branch");

    property p_monitor;
        fetch_done_i && mode[pmx_pkg::MB_MON] |=> cause[pmx_pkg::CB_ANA];
    endproperty
    a_monitor: assert property (p_monitor) // RULE_10
        else $error("monitor analysis request missing");

    property p_wcs;
        !mode[pmx_pkg::MB_EMUL] |-> !wcs_grant_o;
    endproperty
    a_wcs: assert property (p_wcs) // RULE_11
        else $error("control store granted without emulation mode");

    property p_mchk;
        cpu_fault_i || (prog_exc && !pmask) |=> cause[pmx_pkg::CB_MCHK];
    endproperty
    a_mchk: assert property (p_mchk) // RULE_15
        else $error("machine check not raised");

    property p_int_sup;
        int_ack_i |=> !mode[pmx_pkg::MB_PROB] && !gpr_adr_o[pmx_pkg::GPR_W];
    endproperty
    a_int_sup: assert property (p_int_sup) // RULE_18
        else $error("interrupt did not enter supervisor state");

    property p_timer_hold;
        expire |=> cause[pmx_pkg::CB_TMR] ##1
            (cause[pmx_pkg::CB_TMR] || $past(clr[pmx_pkg::CB_TMR]));
    endproperty
    a_timer_hold: assert property (p_timer_hold) // RULE_20
        else $error("timer request lost before acknowledge");
endmodule

// ==== shared/pmx_pkg.sv ====
// Function
// RULE_01 - seven mode bits select processor operating modes
// RULE_02 - problem mode refuses privileged instructions
// RULE_03 - privileged op in problem mode raises exception
// RULE_04 - key protection also applies in supervisor mode
// RULE_05 - storage key mismatch raises protection exception
// RULE_06 - register bank follows problem register mode bit
// RULE_07 - code bit selects ASCII or EBCDIC interpretation
// RULE_08 - wait stops fetching, interrupts still accepted
// RULE_09 - trace writes next address and length code
// RULE_10 - monitor raises analysis interrupt before each instruction
// RULE_11 - emulation bit gates writable control storage
// RULE_12 - both timer counters step once per millisecond
// RULE_13 - running counter wraps up or down silently
// RULE_14 - interval from one millisecond to sixty-four seconds
// RULE_15 - machine check on faults or masked program exception
// RULE_16 - undefined opcode or missing feature raises exception
// RULE_17 - execute targeting execute raises exception
// RULE_18 - taking interrupt switches to supervisor state
// RULE_19 - interval expiry posts timer interrupt request
// RULE_20 - interval counter loads, decrements, holds request
package pmx_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int MODE_W = 7;
    localparam int MB_PROB = 0;
    localparam int MB_UREGS = 1;
    localparam int MB_ASCII = 2;
    localparam int MB_WAIT = 3;
    localparam int MB_TRACE = 4;
    localparam int MB_MON = 5;
    localparam int MB_EMUL = 6;
    localparam logic [MODE_W-1:0] MODE_RST = 7'h00;
    localparam int KEY_W = 4;
    localparam int CTRL_PMASK = 8;
    localparam logic [KEY_W-1:0] KEY_RST = 4'h0;
    localparam int CAUSE_W = 7;
    localparam int CB_OP = 0;
    localparam int CB_PRIV = 1;
    localparam int CB_EXEC = 2;
    localparam int CB_PROT = 3;
    localparam int CB_ANA = 4;
    localparam int CB_MCHK = 5;
    localparam int CB_TMR = 6;
    localparam int TA_W = 24;
    localparam int TP_W = 8;
    localparam int ILC_W = 2;
    localparam int TRC_ILC_LSB = 30;
    localparam int TRC_STEP = 4;
    localparam int GPR_W = 4;
    localparam int TCTL_DOWN = 0;
    localparam logic [AW-1:0] ADR_MODE = 8'h00;
    localparam logic [AW-1:0] ADR_CTRL = 8'h04;
    localparam logic [AW-1:0] ADR_CAUSE = 8'h08;
    localparam logic [AW-1:0] ADR_TBASE = 8'h0C;
    localparam logic [AW-1:0] ADR_TPTR = 8'h10;
    localparam logic [AW-1:0] ADR_RUN = 8'h14;
    localparam logic [AW-1:0] ADR_TCTL = 8'h18;
    localparam logic [AW-1:0] ADR_INTV = 8'h1C;
    localparam int RUN_W = 32;
    localparam int INTV_W = 16;
    localparam logic [INTV_W-1:0] INTV_MAX = 16'hFA00;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// ==== core/pmx_timer.sv ====
`timescale 1ns/10ps
module pmx_timer #(
    parameter int unsigned TICK_CYCLES = pmx_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_wr_i,
    input wire logic [pmx_pkg::RUN_W-1:0] run_val_i,
    input wire logic down_i,
    input wire logic intv_wr_i,
    input wire logic [pmx_pkg::INTV_W-1:0] intv_val_i,
    output logic tick_o,
    output logic [pmx_pkg::RUN_W-1:0] run_o,
    output logic [pmx_pkg::INTV_W-1:0] intv_o,
    output logic expire_o
);
    localparam int PRE_W = $clog2(TICK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
    localparam logic [pmx_pkg::INTV_W-1:0] ONE = 16'h0001;

    logic [PRE_W-1:0] pre;
    logic [pmx_pkg::INTV_W-1:0] reload;
    logic [pmx_pkg::INTV_W-1:0] wr_val;

    always_ff @(posedge clk_i) begin
        if (rst_i || pre == PRE_LAST) begin
            pre <= '0;
        end else begin
            pre <= pre + PRE_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= (pre == PRE_LAST);
        end
    end

    // software load wins over a tick landing in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_o <= '0;
        end else if (run_wr_i) begin
            run_o <= run_val_i;
        end else if (tick_o) begin
            run_o <= down_i ? run_o - pmx_pkg::RUN_W'(1) : // RULE_13
                              run_o + pmx_pkg::RUN_W'(1); // RULE_12
        end
    end

    // values above the longest interval are clamped to it
    assign wr_val = (intv_val_i > pmx_pkg::INTV_MAX) ? pmx_pkg::INTV_MAX
                                                       : intv_val_i; // RULE_14

    // zero stops the interval timer; otherwise it reloads on expiry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intv_o <= '0;
            reload <= '0;
            expire_o <= 1'b0;
        end else if (intv_wr_i) begin
            intv_o <= wr_val; // RULE_20
            reload <= wr_val;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (tick_o && intv_o != '0) begin
                if (intv_o == ONE) begin
                    intv_o <= reload;
                    expire_o <= 1'b1; // RULE_19
                end else begin
                    intv_o <= intv_o - ONE; // RULE_12
                end
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_run_step;
        tick_o && !run_wr_i && !down_i |=> run_o == $past(run_o) + 1;
    endproperty
    a_run_step: assert property (p_run_step) // RULE_13
        else $error("running counter did not step up by one");

    property p_run_hold;
        !tick_o && !run_wr_i |=> $stable(run_o);
    endproperty
    a_run_hold: assert property (p_run_hold) // RULE_12
        else $error("running counter moved without a tick");
endmodule

// ==== tb/pmx_seq_model.sv ====
`timescale 1ns/10ps
module pmx_seq_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic int_req_i,
    input wire logic fetch_en_i,
    input wire logic ack_en_i,
    input wire logic fetch_on_i,
    output logic int_ack_o,
    output logic fetch_done_o
);
    logic req_q;
    logic [2:0] dly;
    logic [1:0] div;
    // slow taker: the ack lands five cycles after the request rises
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_q <= 1'b0;
            dly <= 3'h0;
            int_ack_o <= 1'b0;
        end else begin
            req_q <= int_req_i;
            int_ack_o <= (dly == 3'h1);
            if (int_req_i && !req_q && ack_en_i) begin
                dly <= 3'h4;
            end else if (dly != 3'h0) begin
                dly <= dly - 3'h1;
            end
        end
    end
    // fetches only while the core allows it, one every four cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div <= 2'h0;
            fetch_done_o <= 1'b0;
        end else begin
            div <= div + 2'h1;
            fetch_done_o <= fetch_on_i && fetch_en_i && div == 2'h3;
        end
    end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    localparam int TC = 8;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0, stb = 0, we = 0, dv = 0, dp = 0, du = 0, df = 0;
    logic dx = 0, dt = 0, sv = 0, bt = 0, wr = 0, cf = 0, iof = 0;
    logic ios = 0, ack_en = 0, fon = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0, sk = 0, gn = 0;
    logic [23:0] bia = 0;
    logic [1:0] bilc = 0;
    logic [31:0] wdat = 0;
    logic [31:0] rdat, tdat, q, a, v, k;
    logic ack, allow, fen, sok, asc, twr, wg, ireq, ia, fd;
    logic [4:0] gadr;
    logic [23:0] tadr, base;
    logic [25:0] tq[$];
    int bad_count = 0, tests_run = 0, cyc_n = 0, t_ack = 0;
    int n, t, i, m_cause;

    always #4 clk_i = ~clk_i;

    pmx_core #(.TICK_CYCLES(TC)) u_pmx_core (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dec_valid_i(dv), .dec_priv_i(dp), .dec_undef_i(du),
        .dec_feat_miss_i(df), .dec_is_exec_i(dx), .dec_exec_tgt_i(dt),
        .dec_allow_o(allow), .fetch_en_o(fen), .fetch_done_i(fd),
        .stor_valid_i(sv), .stor_key_i(sk), .stor_ok_o(sok),
        .gpr_num_i(gn), .gpr_adr_o(gadr), .ascii_o(asc),
        .br_taken_i(bt), .br_next_ia_i(bia), .br_ilc_i(bilc),
        .trace_wr_o(twr), .trace_adr_o(tadr), .trace_dat_o(tdat),
        .wcs_req_i(wr), .wcs_grant_o(wg), .cpu_fault_i(cf),
        .io_fault_i(iof), .io_subsys_i(ios), .int_req_o(ireq),
        .int_ack_i(ia));

    pmx_seq_model u_pmx_seq_model (.clk_i(clk_i), .rst_i(rst_i),
        .int_req_i(ireq), .fetch_en_i(fen), .ack_en_i(ack_en),
        .fetch_on_i(fon), .int_ack_o(ia), .fetch_done_o(fd));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // whole run is about 500 cycles, so this only trips on a hang
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            bad_count++;
            end_sim;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // entered right after a rising edge; returns right after one
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d, input logic [3:0] s);
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= ad;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        t_ack = cyc_n;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask

    task automatic wr32(input logic [7:0] ad, input logic [31:0] d);
        wb(1, ad, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        wb(0, ad, 32'h0, 4'hF);
        chk(q, exp);
    endtask

    task automatic clr;
        wr32(pmx_pkg::ADR_CAUSE, 32'h7F);
        m_cause = 0;
    endtask

    task automatic dec(input logic [4:0] f, input logic ea);
        dv <= 1;
        {dp, du, df, dx, dt} <= f;
        #1 chk(allow, ea);
        @(posedge clk_i);
        dv <= 0;
        {dp, du, df, dx, dt} <= 5'h00;
        @(posedge clk_i);
    endtask

    task automatic span(input logic [31:0] d, input int l);
        chk(d >= l / TC && d <= (l + TC - 1) / TC, 1);
    endtask

    initial begin
        void'($urandom(32'h98e17bc0));
        m_cause = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        rd(pmx_pkg::ADR_MODE, 32'h0);
        rd(pmx_pkg::ADR_CTRL, 32'h100);
        wb(1, pmx_pkg::ADR_MODE, 32'h7F, 4'h0);
        rd(pmx_pkg::ADR_MODE, 32'h0);
        wr32(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        $display("reset and bus done");
        for (i = 0; i < 6; i++) begin
            v = $urandom & 32'h7F;
            wr32(pmx_pkg::ADR_MODE, v);
            gn <= $urandom;
            wr <= $urandom;
            #1 chk(asc, v[2]);
            chk(gadr, {v[1], gn});
            chk(wg, wr & v[6]);
            chk(fen, !v[3]);
            @(posedge clk_i);
            rd(pmx_pkg::ADR_MODE, v);
        end
        $display("mode bits done");
        wr32(pmx_pkg::ADR_MODE, 32'h1);
        dec(5'h10, 0);
        rd(pmx_pkg::ADR_CAUSE, 32'h2);
        wr32(pmx_pkg::ADR_MODE, 32'h0);
        clr;
        dec(5'h10, 1);
        dec(5'h02, 1);
        dec(5'h01, 1);
        rd(pmx_pkg::ADR_CAUSE, 32'h0);
        dec(5'h08, 0);
        rd(pmx_pkg::ADR_CAUSE, 32'h1);
        clr;
        dec(5'h04, 0);
        dec(5'h03, 0);
        rd(pmx_pkg::ADR_CAUSE, 32'h5);
        clr;
        $display("decode done");
        k = $urandom & 32'hF;
        wr32(pmx_pkg::ADR_CTRL, 32'h100 | k);
        for (i = 0; i < 2; i++) begin
            wr32(pmx_pkg::ADR_MODE, i);
            sv <= 1;
            sk <= k;
            #1 chk(sok, 1);
            @(posedge clk_i);
            sk <= k ^ 4'h9;
            #1 chk(sok, 0);
            @(posedge clk_i);
            sv <= 0;
            @(posedge clk_i);
            rd(pmx_pkg::ADR_CAUSE, 32'h8);
            clr;
        end
        $display("protection done");
        for (i = 0; i < 3; i++) begin
            v = (i == 0) ? 32'h4 : (i == 1) ? 32'h3 : 32'h2;
            {cf, iof, ios} <= v[2:0];
            @(posedge clk_i);
            {cf, iof, ios} <= 3'h0;
            @(posedge clk_i);
            rd(pmx_pkg::ADR_CAUSE, (i == 1) ? 32'h0 : 32'h20);
            clr;
        end
        wr32(pmx_pkg::ADR_CTRL, k);
        wr32(pmx_pkg::ADR_MODE, 32'h1);
        dec(5'h10, 0);
        rd(pmx_pkg::ADR_CAUSE, 32'h20);
        wr32(pmx_pkg::ADR_CTRL, 32'h100 | k);
        clr;
        $display("machine check done");
        base = $urandom & 24'hFFFFF0;
        wr32(pmx_pkg::ADR_TBASE, base);
        wr32(pmx_pkg::ADR_MODE, 32'h10);
        for (i = 0; i < 3; i++) begin
            v = $urandom;
            if (i < 2) tq.push_back(v[25:0]);
            bt <= (i < 2);
            bia <= v[23:0];
            bilc <= v[25:24];
            @(posedge clk_i);
            // outputs seen here were launched by the previous edge
            if (i > 0) begin
                chk(twr, 1);
                chk(tadr, base + 4 * (i - 1));
                chk({tdat[31:30], tdat[23:0]}, tq.pop_front());
            end
        end
        @(posedge clk_i);
        chk(twr, 0);
        rd(pmx_pkg::ADR_TPTR, 32'h2);
        $display("trace done");
        wr32(pmx_pkg::ADR_MODE, 32'h20);
        fon <= 1;
        repeat (12) @(posedge clk_i);
        rd(pmx_pkg::ADR_CAUSE, 32'h10);
        wr32(pmx_pkg::ADR_MODE, 32'h0F);
        clr;
        n = 0;
        for (i = 0; i < 24; i++) begin
            @(posedge clk_i);
            if (fd === 1'b1) t++;
            if (fd === 1'b1) n = 99;
        end
        chk(n, 0);
        ack_en <= 1;
        cf <= 1;
        @(posedge clk_i);
        cf <= 0;
        repeat (10) @(posedge clk_i);
        rd(pmx_pkg::ADR_MODE, 32'h04);
        ack_en <= 0;
        fon <= 0;
        clr;
        $display("monitor wait interrupt done");
        wr32(pmx_pkg::ADR_TCTL, 32'h0);
        wr32(pmx_pkg::ADR_RUN, $urandom);
        for (i = 0; i < 2; i++) begin
            wb(0, pmx_pkg::ADR_RUN, 32'h0, 4'hF);
            a = q;
            t = t_ack;
            repeat (45) @(posedge clk_i);
            wb(0, pmx_pkg::ADR_RUN, 32'h0, 4'hF);
            span((i == 0) ? q - a : a - q, t_ack - t);
            wr32(pmx_pkg::ADR_TCTL, 32'h1);
            wr32(pmx_pkg::ADR_RUN, 32'h1);
        end
        chk(ireq, 0);
        for (i = 1; i < 4; i += 2) begin
            wr32(pmx_pkg::ADR_INTV, 32'h0);
            clr;
            wr32(pmx_pkg::ADR_INTV, i);
            n = 0;
            while (ireq !== 1'b1 && n < 100) begin
                @(posedge clk_i);
                n++;
            end
            chk(n >= TC * i - 9 && n <= TC * i + 2, 1);
            rd(pmx_pkg::ADR_CAUSE, 32'h40);
        end
        wr32(pmx_pkg::ADR_INTV, 32'h0);
        clr;
        repeat (40) @(posedge clk_i);
        chk(ireq, 0);
        $display("timer done");
        end_sim;
    end
endmodule
